/* spi_far_target.sv */
// Purpose: far-side serial target for controller transfers
// Assumes: a low select pin frames one byte
// Notes: between frames the data line shows the inverse of its last value
`timescale 1ns/1ps
module spi_far_target
(
    input wire logic i_sck, // clock pin
    input wire logic i_sel_n, // select pin
    input wire logic i_mosi, // data in
    input wire logic i_cpol, // clock idle level
    input wire logic i_cpha, // clock phase
    input wire logic i_lsb, // low bit first
    input wire logic [7:0] i_tx, // byte to send
    output logic o_miso, // data out
    output logic [7:0] o_rx // byte taken
);
    logic [7:0] sh;
    int n;
    initial o_miso = 1'b0;
    initial o_rx = 8'h00;
    always @(negedge i_sel_n)
    begin
        sh = i_tx;
        n = 0;
        if (!i_cpha)
            o_miso = i_lsb ? sh[0] : sh[7];
    end
    always @(posedge i_sel_n) o_miso = ~o_miso;
    always @(i_sck)
    begin
        if (!i_sel_n && n < 8)
        begin
            if ((i_sck != i_cpol) != i_cpha)
            begin
                o_rx[i_lsb ? n : 7 - n] = i_mosi;
                n = n + 1;
            end
            else
                o_miso = sh[i_lsb ? n : 7 - n];
        end
    end
endmodule : spi_far_target

/* spi_pin_mode_control.sv */
// Purpose: pin routing, mode control and byte engine of a serial peripheral interface
// Assumes: power-mode inputs come from the same clock; pin inputs are asynchronous
// Notes: pins split into level, drive and enable; O_PIN_OWN steers the port mux
// Notes on behaviour
// - two-wire: controller reads MISO, target drives it
// - single-wire target: MISO is the bidirectional pin
// - single-wire controller: MISO returned to port
// - target: select pin is active-low select input
// - controller select pin: port, fault input, auto-select
// - stop modes disable; deep stop resets everything but the pin synchronisers
// - light stop halts clocks, keeps all state
// - bit 7 enables receive-full/fault interrupt request
// - disable aborts, clears receive-full, sets transmit-empty
// - bit 5 enables transmit-empty interrupt request
// - bit 4: 0 target, 1 controller
// - bit 3: clock idles low or high
// - bit 2: first edge mid or start of bit
// - bit 0: most or least significant first
// - shared pin direction set by its output enable
// - wait-stop bit halts clocks in wait mode
// - single-wire: MOSI for controller, MISO for target
// - control-two bits 7,6,5,2 read zero
// - fault enable ignored as target; 0 frees select
// - disabled interface releases all four pins
// - single-wire target: MOSI returned to port
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps

module spi_pin_mode_control
(
    input wire logic I_CORE_CLK, // core clock, 40 MHz
    input wire logic I_ARST_N, // asynchronous reset, active low
    input wire logic [1:0] I_ADDR, // register index
    input wire logic [7:0] I_WDATA, // write data
    input wire logic I_WR, // write strobe
    input wire logic I_RD, // read strobe
    output logic [7:0] O_RDATA, // read data, cycle after the strobe
    input wire logic I_STOP_DEEP, // deepest stop modes, powered down
    input wire logic I_STOP_LIGHT, // lightest stop mode, clocks halted
    input wire logic I_WAIT, // processor in wait mode
    input wire logic I_SCK, // serial clock pin level
    output logic O_SCK, // serial clock drive value
    output logic O_SCK_OE, // serial clock drive enable
    input wire logic I_MOSI, // MOSI pin level
    output logic O_MOSI, // MOSI drive value
    output logic O_MOSI_OE, // MOSI drive enable
    input wire logic I_MISO, // MISO pin level
    output logic O_MISO, // MISO drive value
    output logic O_MISO_OE, // MISO drive enable
    input wire logic I_SEL_N, // select pin level, active low
    output logic O_SEL_N, // select drive value, active low
    output logic O_SEL_OE, // select drive enable
    output logic [3:0] O_PIN_OWN, // pins claimed by the interface: sel, miso, mosi, sck
    output logic O_IRQ // interrupt request, level
);

    logic [7:0] control_one_q, control_two_q, tx_buf_q, rx_buf_q, tx_sh_q, rx_sh_q, hp_cnt_q;
    logic [3:0] sync1_q, sync2_q, sync3_q, pin_st_q, edge_cnt_q, samp_cnt_q;
    logic fault_q, tx_full_q, rx_full_q, out_bit_q, sck_lvl_q;
    spi_pin_mode_pkg::engine_state_type state_q;

    function automatic logic first_bit(input logic [7:0] v, input logic lsb);
        return lsb ? v[0] : v[7];
    endfunction : first_bit

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
        return lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shift_in

    logic sys_en, controller, cpol, cpha, lsb_first, sel_oe_bit, fault_en, pin_oe_bit, single_wire, halt, active;
    logic sel_low, sck_chg, m_edge, m_samp, lead, ev, sample, drive, data_in, done, fault_set, start_m, start_s;
    logic [7:0] rx_next, load_word;

    assign sys_en = control_one_q[spi_pin_mode_pkg::C1_SYSTEM_ENABLE];
    assign controller = control_one_q[spi_pin_mode_pkg::C1_CONTROLLER_SELECT];
    assign cpol = control_one_q[spi_pin_mode_pkg::C1_CLOCK_POLARITY];
    assign cpha = control_one_q[spi_pin_mode_pkg::C1_CLOCK_PHASE];
    assign lsb_first = control_one_q[spi_pin_mode_pkg::C1_LOW_BIT_FIRST];
    assign sel_oe_bit = control_one_q[spi_pin_mode_pkg::C1_SELECT_OUTPUT_ENABLE];
    assign fault_en = control_two_q[spi_pin_mode_pkg::C2_FAULT_DETECT_ENABLE];
    assign pin_oe_bit = control_two_q[spi_pin_mode_pkg::C2_SHARED_PIN_OUTPUT_ENABLE];
    assign single_wire = control_two_q[spi_pin_mode_pkg::C2_SINGLE_WIRE_SELECT];

    // clocks halted: light stop, or wait with the stop bit set
    assign halt = I_STOP_LIGHT | (I_WAIT & control_two_q[spi_pin_mode_pkg::C2_WAIT_CLOCK_STOP]);
    assign active = sys_en & ~I_STOP_DEEP & ~I_STOP_LIGHT;

    // select is always an active-low input as target, whatever fault/output enable say
    assign sel_low = ~pin_st_q[spi_pin_mode_pkg::PIN_SEL];

    // clock edge counts only once the second and third stages agree
    assign sck_chg = (sync2_q[spi_pin_mode_pkg::PIN_SCK] == sync3_q[spi_pin_mode_pkg::PIN_SCK])
        & (sync3_q[spi_pin_mode_pkg::PIN_SCK] != pin_st_q[spi_pin_mode_pkg::PIN_SCK]);

    assign m_edge = (state_q == spi_pin_mode_pkg::ENG_RUN) & controller & (hp_cnt_q == spi_pin_mode_pkg::HALF_LAST);

    // a target's leading edge leaves the idle level set by polarity
    assign lead = controller ? ~edge_cnt_q[0] : (sync3_q[spi_pin_mode_pkg::PIN_SCK] ^ cpol);
    assign ev = (state_q == spi_pin_mode_pkg::ENG_RUN) & (controller ? m_edge : (sck_chg & sel_low));

    // the far side answers our edge late and the synchroniser adds more, so sample mid half period
    assign m_samp = (state_q == spi_pin_mode_pkg::ENG_RUN) & controller & (hp_cnt_q == spi_pin_mode_pkg::SAMPLE_LAG)
        & (edge_cnt_q[0] == ~cpha) & ((edge_cnt_q != 4'h0) | (samp_cnt_q != 4'h0));
    // phase 0 samples on leading edges, phase 1 on trailing edges
    assign sample = controller ? m_samp : (ev & (lead ^ cpha));
    // phase 0 first bit is driven at load, so no drive before the first sample
    assign drive = ev & ~(lead ^ cpha) & ~(~cpha & (samp_cnt_q == 4'h0));

    assign data_in = (single_wire == controller) ? pin_st_q[spi_pin_mode_pkg::PIN_MOSI]
        : pin_st_q[spi_pin_mode_pkg::PIN_MISO];

    assign rx_next = sample ? shift_in(rx_sh_q, data_in, lsb_first) : rx_sh_q;
    assign done = sample & (samp_cnt_q == spi_pin_mode_pkg::SAMPLE_LAST);
    assign fault_set = active & controller & fault_en & ~sel_oe_bit & sel_low;
    assign start_m = (state_q == spi_pin_mode_pkg::ENG_IDLE) & active & controller & tx_full_q & ~fault_q;
    assign start_s = active & ~controller & sel_low & ((state_q == spi_pin_mode_pkg::ENG_IDLE) | done);
    // a target with nothing queued resends whatever is left in the shifter
    assign load_word = tx_full_q ? tx_buf_q : tx_sh_q;

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            control_one_q <= spi_pin_mode_pkg::RESET_CONTROL_ONE;
            control_two_q <= spi_pin_mode_pkg::RESET_CONTROL_TWO;
        end
        else if (I_STOP_DEEP)
        begin
            control_one_q <= spi_pin_mode_pkg::RESET_CONTROL_ONE;
            control_two_q <= spi_pin_mode_pkg::RESET_CONTROL_TWO;
        end
        else if (I_WR)
        begin
            if (I_ADDR == spi_pin_mode_pkg::OFS_CONTROL_ONE)
            begin
                control_one_q <= I_WDATA;
            end
            if (I_ADDR == spi_pin_mode_pkg::OFS_CONTROL_TWO)
            begin
                control_two_q <= I_WDATA & spi_pin_mode_pkg::C2_IMPLEMENTED;
            end
        end
    end

    // fault flag: a new fault wins over the clearing write
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            fault_q <= 1'b0;
        end
        else if (I_STOP_DEEP)
        begin
            fault_q <= 1'b0;
        end
        else if (fault_set && !halt)
        begin
            fault_q <= 1'b1;
        end
        else if (I_WR && I_ADDR == spi_pin_mode_pkg::OFS_CONTROL_ONE)
        begin
            fault_q <= 1'b0;
        end
    end

    // three-stage synchronisers; only the second stage reads the first
    for (genvar g = 0; g < spi_pin_mode_pkg::PIN_COUNT; g++)
    begin : g_sync
        always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
        begin
            if (!I_ARST_N)
            begin
                sync1_q[g] <= spi_pin_mode_pkg::PIN_IDLE[g];
                sync2_q[g] <= spi_pin_mode_pkg::PIN_IDLE[g];
                sync3_q[g] <= spi_pin_mode_pkg::PIN_IDLE[g];
                pin_st_q[g] <= spi_pin_mode_pkg::PIN_IDLE[g];
            end
            else
            begin
                sync1_q[g] <= (g == spi_pin_mode_pkg::PIN_SCK) ? I_SCK
                    : (g == spi_pin_mode_pkg::PIN_MOSI) ? I_MOSI
                    : (g == spi_pin_mode_pkg::PIN_MISO) ? I_MISO : I_SEL_N;
                sync2_q[g] <= sync1_q[g];
                sync3_q[g] <= sync2_q[g];
                if (sync2_q[g] == sync3_q[g])
                begin
                    pin_st_q[g] <= sync3_q[g];
                end
            end
        end
    end

    // byte engine, data buffers and transfer flags
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            state_q <= spi_pin_mode_pkg::ENG_IDLE;
            tx_buf_q <= spi_pin_mode_pkg::RESET_DATA;
            tx_full_q <= 1'b0;
            rx_buf_q <= spi_pin_mode_pkg::RESET_DATA;
            rx_full_q <= 1'b0;
            tx_sh_q <= spi_pin_mode_pkg::RESET_DATA;
            rx_sh_q <= spi_pin_mode_pkg::RESET_DATA;
            out_bit_q <= 1'b0;
            hp_cnt_q <= 8'h00;
            edge_cnt_q <= 4'h0;
            samp_cnt_q <= 4'h0;
            sck_lvl_q <= 1'b0;
        end
        else if (I_STOP_DEEP || !sys_en)
        begin
            // abort, reinitialise, receive not full, transmit empty
            state_q <= spi_pin_mode_pkg::ENG_IDLE;
            tx_full_q <= 1'b0;
            rx_full_q <= 1'b0;
            hp_cnt_q <= 8'h00;
            edge_cnt_q <= 4'h0;
            samp_cnt_q <= 4'h0;
            sck_lvl_q <= cpol;
            if (I_STOP_DEEP)
            begin
                tx_buf_q <= spi_pin_mode_pkg::RESET_DATA;
                rx_buf_q <= spi_pin_mode_pkg::RESET_DATA;
                tx_sh_q <= spi_pin_mode_pkg::RESET_DATA;
                rx_sh_q <= spi_pin_mode_pkg::RESET_DATA;
                out_bit_q <= 1'b0;
            end
        end
        else
        begin
            // writes while the buffer holds a byte are dropped
            if (I_WR && I_ADDR == spi_pin_mode_pkg::OFS_DATA && !tx_full_q)
            begin
                tx_buf_q <= I_WDATA;
                tx_full_q <= 1'b1;
            end
            if (I_RD && I_ADDR == spi_pin_mode_pkg::OFS_DATA)
            begin
                rx_full_q <= 1'b0;
            end
            if (!halt)
            begin
                unique case (state_q)
                    spi_pin_mode_pkg::ENG_IDLE:
                    begin
                        sck_lvl_q <= cpol;
                        hp_cnt_q <= 8'h00;
                        edge_cnt_q <= 4'h0;
                        samp_cnt_q <= 4'h0;
                    end
                    spi_pin_mode_pkg::ENG_RUN:
                    begin
                        if (controller)
                        begin
                            hp_cnt_q <= m_edge ? 8'h00 : hp_cnt_q + 8'h01;
                        end
                        if (m_edge)
                        begin
                            sck_lvl_q <= ~sck_lvl_q;
                            edge_cnt_q <= edge_cnt_q + 4'h1;
                        end
                        if (sample)
                        begin
                            rx_sh_q <= rx_next;
                            samp_cnt_q <= samp_cnt_q + 4'h1;
                        end
                        if (drive)
                        begin
                            out_bit_q <= first_bit(tx_sh_q, lsb_first);
                            tx_sh_q <= shift_in(tx_sh_q, 1'b0, lsb_first);
                        end
                        if (done)
                        begin
                            rx_buf_q <= rx_next;
                            rx_full_q <= 1'b1;
                            samp_cnt_q <= 4'h0;
                            edge_cnt_q <= 4'h0;
                            state_q <= spi_pin_mode_pkg::ENG_IDLE;
                        end
                        if ((!controller && !sel_low) || fault_set)
                        begin
                            state_q <= spi_pin_mode_pkg::ENG_IDLE;
                        end
                    end
                endcase
                if (start_m || start_s)
                begin
                    state_q <= spi_pin_mode_pkg::ENG_RUN;
                    tx_full_q <= 1'b0;
                    if (!cpha)
                    begin
                        // phase 0: first bit must stand before the first edge
                        out_bit_q <= first_bit(load_word, lsb_first);
                        tx_sh_q <= shift_in(load_word, 1'b0, lsb_first);
                    end
                    else
                    begin
                        tx_sh_q <= load_word;
                    end
                end
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_RDATA <= 8'h00;
        end
        else if (I_RD)
        begin
            unique case (I_ADDR)
                spi_pin_mode_pkg::OFS_CONTROL_ONE: O_RDATA <= control_one_q;
                spi_pin_mode_pkg::OFS_CONTROL_TWO: O_RDATA <= control_two_q;
                spi_pin_mode_pkg::OFS_STATUS:
                begin
                    O_RDATA <= 8'h00;
                    O_RDATA[spi_pin_mode_pkg::ST_RX_BUFFER_FULL] <= rx_full_q;
                    O_RDATA[spi_pin_mode_pkg::ST_TX_BUFFER_EMPTY] <= ~tx_full_q;
                    O_RDATA[spi_pin_mode_pkg::ST_FAULT_FLAG] <= fault_q;
                end
                spi_pin_mode_pkg::OFS_DATA: O_RDATA <= rx_buf_q;
            endcase
        end
        else
        begin
            O_RDATA <= 8'h00;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_IRQ <= 1'b0;
        end
        else
        begin
            O_IRQ <= (control_one_q[spi_pin_mode_pkg::C1_RX_FAULT_IRQ_ENABLE] & (rx_full_q | fault_q))
                | (control_one_q[spi_pin_mode_pkg::C1_TX_IRQ_ENABLE] & ~tx_full_q);
        end
    end

    // pin routing; all pins released while the interface is not active
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_SCK <= 1'b0;
            O_SCK_OE <= 1'b0;
            O_MOSI <= 1'b0;
            O_MOSI_OE <= 1'b0;
            O_MISO <= 1'b0;
            O_MISO_OE <= 1'b0;
            O_SEL_N <= 1'b1;
            O_SEL_OE <= 1'b0;
            O_PIN_OWN <= 4'h0;
        end
        else
        begin
            O_SCK <= sck_lvl_q;
            O_MOSI <= out_bit_q;
            O_MISO <= out_bit_q;
            // auto-select low only while a byte is moving
            O_SEL_N <= ~(state_q == spi_pin_mode_pkg::ENG_RUN);
            O_SCK_OE <= active & controller;
            O_PIN_OWN[spi_pin_mode_pkg::PIN_SCK] <= active;
            O_PIN_OWN[spi_pin_mode_pkg::PIN_MOSI] <= active & ~(single_wire & ~controller);
            O_PIN_OWN[spi_pin_mode_pkg::PIN_MISO] <= active & ~(single_wire & controller);
            O_PIN_OWN[spi_pin_mode_pkg::PIN_SEL] <= active & (~controller | fault_en);
            // shared-pin enable only counts in single-wire mode
            O_MOSI_OE <= active & controller & (~single_wire | pin_oe_bit);
            // a target drives only while selected, so several can share MISO
            O_MISO_OE <= active & ~controller & sel_low & (~single_wire | pin_oe_bit);
            O_SEL_OE <= active & controller & fault_en & sel_oe_bit;
        end
    end

endmodule : spi_pin_mode_control

/* spi_pin_mode_pkg.sv */
// Purpose: shared constants for the serial peripheral pin and mode control block
// Assumes: 8-bit registers on a small word-indexed register port
// Notes: all offsets, fields and counts live here
package spi_pin_mode_pkg;
    // register offsets on the plain register port
    localparam logic [1:0] OFS_CONTROL_ONE = 2'h0;
    localparam logic [1:0] OFS_CONTROL_TWO = 2'h1;
    localparam logic [1:0] OFS_STATUS = 2'h2;
    localparam logic [1:0] OFS_DATA = 2'h3;

    // spi_control_one fields
    localparam int C1_RX_FAULT_IRQ_ENABLE = 7;
    localparam int C1_SYSTEM_ENABLE = 6;
    localparam int C1_TX_IRQ_ENABLE = 5;
    localparam int C1_CONTROLLER_SELECT = 4;
    localparam int C1_CLOCK_POLARITY = 3;
    localparam int C1_CLOCK_PHASE = 2;
    localparam int C1_SELECT_OUTPUT_ENABLE = 1;
    localparam int C1_LOW_BIT_FIRST = 0;

    // spi_control_two fields
    localparam int C2_FAULT_DETECT_ENABLE = 4;
    localparam int C2_SHARED_PIN_OUTPUT_ENABLE = 3;
    localparam int C2_WAIT_CLOCK_STOP = 1;
    localparam int C2_SINGLE_WIRE_SELECT = 0;
    localparam logic [7:0] C2_IMPLEMENTED = 8'h1B;

    // status fields
    localparam int ST_RX_BUFFER_FULL = 7;
    localparam int ST_TX_BUFFER_EMPTY = 5;
    localparam int ST_FAULT_FLAG = 4;

    localparam logic [7:0] RESET_CONTROL_ONE = 8'h04;
    localparam logic [7:0] RESET_CONTROL_TWO = 8'h00;
    localparam logic [7:0] RESET_DATA = 8'h00;

    // pin indices of the synchroniser bank
    localparam int PIN_SCK = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_MISO = 2;
    localparam int PIN_SEL = 3;
    localparam int PIN_COUNT = 4;
    localparam logic [3:0] PIN_IDLE = 4'h8;

    // master serial clock timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_CYC - 1);
    // sample point past the synchroniser lag
    localparam logic [7:0] SAMPLE_LAG = 8'h02;
    localparam logic [3:0] SAMPLE_LAST = 4'h7;

    typedef enum logic {ENG_IDLE, ENG_RUN} engine_state_type;
endpackage : spi_pin_mode_pkg

/* spi_pin_mode_properties.sv */
// Purpose: port checks for the serial pin and mode control block
// Assumes: bound to every instance of the top module
// Notes: pin outputs are registered, so stop checks allow settling cycles
`timescale 1ns/1ps
module spi_pin_mode_properties
(
    input wire logic I_CORE_CLK,
    input wire logic I_ARST_N,
    input wire logic [1:0] I_ADDR,
    input wire logic I_RD,
    input wire logic I_STOP_DEEP,
    input wire logic I_STOP_LIGHT,
    input wire logic [7:0] O_RDATA,
    input wire logic O_SCK,
    input wire logic O_SCK_OE,
    input wire logic O_MOSI_OE,
    input wire logic O_MISO_OE,
    input wire logic O_SEL_OE,
    input wire logic [3:0] O_PIN_OWN,
    input wire logic O_IRQ
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_ARST_N);
    sequence read_of(logic [1:0] a);
        I_RD && I_ADDR == a;
    endsequence
    sequence clock_toggle;
        O_SCK_OE && $changed(O_SCK);
    endsequence
    read_idle_zero_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside its cycle");
    ctl_two_zero_a: assert property (
        read_of(spi_pin_mode_pkg::OFS_CONTROL_TWO) |=> (O_RDATA & ~spi_pin_mode_pkg::C2_IMPLEMENTED) == 8'h00)
        else $error("unused control bits read nonzero");
    deep_stop_free_a: assert property (I_STOP_DEEP [*3] |-> O_PIN_OWN == 4'h0)
        else $error("pins kept in deep stop");
    deep_stop_quiet_a: assert property (I_STOP_DEEP [*3] |-> !O_IRQ)
        else $error("request raised in deep stop");
    light_stop_free_a: assert property (I_STOP_LIGHT [*3] |-> O_PIN_OWN == 4'h0)
        else $error("pins kept in light stop");
    ctl_miso_in_a: assert property (O_SCK_OE |-> !O_MISO_OE)
        else $error("controller drives its input pin");
    tgt_mosi_free_a: assert property (O_MISO_OE |-> !O_MOSI_OE)
        else $error("target drives both data pins");
    sel_out_ctl_a: assert property (O_SEL_OE |-> O_SCK_OE && O_PIN_OWN[3])
        else $error("select driven outside controller mode");
    owned_drive_a: assert property (
        ({O_SEL_OE, O_MISO_OE, O_MOSI_OE, O_SCK_OE} & ~O_PIN_OWN) == 4'h0)
        else $error("pin driven while released");
    sck_half_a: assert property (clock_toggle |=> (!O_SCK_OE || $stable(O_SCK)) [*3])
        else $error("serial clock half period short");
endmodule : spi_pin_mode_properties

bind spi_pin_mode_control spi_pin_mode_properties props (.*);

/* test_spi_pin_mode_control.sv */
// Purpose: self-checking bench for the pin and mode control block
// Assumes: pull-up on select, pull-down on clock and MOSI, far-side target on MISO
// Notes: controller bytes cross against the far-side target model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_spi_pin_mode_control;
    typedef struct {logic [7:0] c1; logic [7:0] c2; logic [3:0] own; logic [3:0] oe; logic irq;} row_type;
    row_type rows [12] = '{
        '{8'h00, 8'h00, 4'h0, 4'h0, 1'b0}, '{8'h10, 8'hFF, 4'h0, 4'h0, 1'b0}, '{8'h50, 8'h00, 4'h7, 4'h3, 1'b0},
        '{8'hD0, 8'h10, 4'hF, 4'h3, 1'b0}, '{8'h52, 8'h10, 4'hF, 4'hB, 1'b0}, '{8'h52, 8'h00, 4'h7, 4'h3, 1'b0},
        '{8'h70, 8'h09, 4'h3, 4'h3, 1'b1}, '{8'h50, 8'h01, 4'h3, 4'h1, 1'b0}, '{8'h40, 8'h00, 4'hF, 4'h0, 1'b0},
        '{8'h40, 8'h10, 4'hF, 4'h0, 1'b0}, '{8'h40, 8'h09, 4'hD, 4'h0, 1'b0}, '{8'h42, 8'h00, 4'hF, 4'h0, 1'b0}};
    logic clk, arst_n, wr, rd, stop_deep, stop_light, sel_low, cpol, cpha, lsb, irq, far_miso;
    logic sck_out, sck_en, mosi_out, mosi_en, miso_out, miso_en, sel_out_n, sel_en;
    logic sck_w, mosi_w, miso_w, sel_w;
    logic [1:0] addr;
    logic [3:0] pin_own;
    logic [7:0] wdata, rdata, v, far_tx, far_rx, tx_b;
    int mismatches = 0;
    int n_checks = 0;
    assign sck_w = sck_en ? sck_out : 1'b0;
    assign mosi_w = mosi_en ? mosi_out : 1'b0;
    assign miso_w = miso_en ? miso_out : far_miso;
    assign sel_w = sel_en ? sel_out_n : !sel_low;
    spi_pin_mode_control DUT
    (
        .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_STOP_DEEP(stop_deep), .I_STOP_LIGHT(stop_light), .I_WAIT(1'b0),
        .I_SCK(sck_w), .O_SCK(sck_out), .O_SCK_OE(sck_en), .I_MOSI(mosi_w), .O_MOSI(mosi_out),
        .O_MOSI_OE(mosi_en), .I_MISO(miso_w), .O_MISO(miso_out), .O_MISO_OE(miso_en), .I_SEL_N(sel_w),
        .O_SEL_N(sel_out_n), .O_SEL_OE(sel_en), .O_PIN_OWN(pin_own), .O_IRQ(irq)
    );
    spi_far_target far
    (
        .i_sck(sck_w), .i_sel_n(sel_w), .i_mosi(mosi_w), .i_cpol(cpol), .i_cpha(cpha), .i_lsb(lsb),
        .i_tx(far_tx), .o_miso(far_miso), .o_rx(far_rx)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    task automatic cfg(input logic [7:0] c2, input logic [7:0] c1);
        wr_reg(spi_pin_mode_pkg::OFS_CONTROL_TWO, c2);
        wr_reg(spi_pin_mode_pkg::OFS_CONTROL_ONE, c1);
    endtask : cfg
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic wait_rx;
        for (int k = 0; k < 60; k++)
        begin
            rd_reg(spi_pin_mode_pkg::OFS_STATUS, v);
            if (v[spi_pin_mode_pkg::ST_RX_BUFFER_FULL] === 1'b1)
                return;
        end
        mismatches++;
        finish_test();
    endtask : wait_rx
    initial
    begin
        {arst_n, wr, rd, stop_deep, stop_light, sel_low, cpol, cpha, lsb} = 9'h000;
        {addr, wdata, far_tx} = 18'h00000;
        repeat (16) @(posedge clk);
        `CHK("sel in reset", 1'b1, sel_out_n)
        arst_n <= 1'b1;
        rd_reg(spi_pin_mode_pkg::OFS_CONTROL_ONE, v);
        `CHK("ctl one reset", spi_pin_mode_pkg::RESET_CONTROL_ONE, v)
        foreach (rows[i])
        begin
            cfg(rows[i].c2, rows[i].c1);
            settle(3);
            `CHK("pin own", rows[i].own, pin_own)
            `CHK("drive en", rows[i].oe, {sel_en, miso_en, mosi_en, sck_en})
            `CHK("irq", rows[i].irq, irq)
            rd_reg(spi_pin_mode_pkg::OFS_CONTROL_ONE, v);
            `CHK("ctl one", rows[i].c1, v)
            rd_reg(spi_pin_mode_pkg::OFS_CONTROL_TWO, v);
            `CHK("ctl two", rows[i].c2 & spi_pin_mode_pkg::C2_IMPLEMENTED, v)
        end
        // every clock format and bit order, one byte each way
        for (int m = 0; m < 8; m++)
        begin
            {cpol, cpha, lsb} = 3'(m);
            far_tx = 8'h5E - 8'(m);
            tx_b = 8'hC1 + 8'(m);
            cfg(8'h10, {4'h5, cpol, cpha, 1'b1, lsb});
            settle(6);
            `CHK("sck idle", cpol, sck_out)
            wr_reg(spi_pin_mode_pkg::OFS_DATA, tx_b);
            wait_rx();
            rd_reg(spi_pin_mode_pkg::OFS_DATA, v);
            `CHK("rx byte", far_tx, v)
            `CHK("far rx", tx_b, far_rx)
        end
        wr_reg(spi_pin_mode_pkg::OFS_DATA, 8'h96);
        settle(20);
        wr_reg(spi_pin_mode_pkg::OFS_CONTROL_ONE, 8'h12);
        rd_reg(spi_pin_mode_pkg::OFS_STATUS, v);
        `CHK("abort flags", 8'h20, v & 8'hA0)
        `CHK("abort pins", 4'h0, pin_own)
        cfg(8'h10, 8'hD0);
        sel_low <= 1'b1;
        settle(8);
        rd_reg(spi_pin_mode_pkg::OFS_STATUS, v);
        `CHK("fault flag", 1'b1, v[spi_pin_mode_pkg::ST_FAULT_FLAG])
        `CHK("fault irq", 1'b1, irq)
        @(posedge clk);
        sel_low <= 1'b0;
        settle(4);
        cfg(8'h00, 8'hD0);
        settle(3);
        `CHK("fault cleared", 1'b0, irq)
        stop_light <= 1'b1;
        settle(4);
        `CHK("light stop", 4'h0, pin_own)
        @(posedge clk);
        stop_light <= 1'b0;
        settle(4);
        `CHK("light resume", 4'h7, pin_own)
        @(posedge clk);
        stop_deep <= 1'b1;
        settle(4);
        `CHK("deep stop", 4'h0, pin_own)
        @(posedge clk);
        stop_deep <= 1'b0;
        rd_reg(spi_pin_mode_pkg::OFS_CONTROL_ONE, v);
        `CHK("deep wake", spi_pin_mode_pkg::RESET_CONTROL_ONE, v)
        cfg(8'h10, 8'h52);
        @(posedge clk);
        arst_n <= 1'b0;
        settle(2);
        `CHK("reset pins", 4'h0, pin_own)
        `CHK("reset sel", 1'b1, sel_out_n)
        @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(spi_pin_mode_pkg::OFS_CONTROL_TWO, v);
        `CHK("ctl two reset", spi_pin_mode_pkg::RESET_CONTROL_TWO, v)
        finish_test();
    end
endmodule : test_spi_pin_mode_control
